//--- hdl/bbcc_converter_control.sv
// Behaviour
// - Enable bit 0 resets low; 1 hands over
// - Ceiling bits 15:12, 6 mA steps, reset 8
// - Floor bits 11:8, same steps, reset 4
// - Output-ok clears after 2/4/8/15 consecutive fails
// - Switch on beyond timeout forces next phase
// - Idle monitoring rate divides clock by 4..32
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module bbcc_converter_control (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Power stage comparators
    input  wire logic        outputOkSample,
    input  wire logic        peakReached,
    input  wire logic        needEnergy,
    // Power stage controls
    output logic             converterOn,
    output logic             highSwitchOn,
    output logic             lowSwitchOn,
    output logic             outputSampleStrobe,
    output logic [3:0]       peakLimitActive,
    output logic             output_ok_flag
);
    typedef struct packed {
        bbcc_pkg::bbcc_ctrl_t  ctrl;
        bbcc_pkg::bbcc_phase_t phase;
        logic [3:0]            peakLimit;
        logic [3:0]            failRun;
        logic                  outputOk;
        logic                  sampleStrobe;
        logic                  awTaken;
        logic                  wTaken;
        logic [31:0]           awAddr;
        logic [31:0]           wData;
        logic [3:0]            wStrb;
        logic                  bValid;
        logic [1:0]            bResp;
        logic                  rValid;
        logic [31:0]           rData;
        logic [1:0]            rResp;
        logic                  arReady;
        logic                  onOut;
        logic                  highOut;
        logic                  lowOut;
    } bbcc_state_t;

    bbcc_state_t state;
    bbcc_state_t next_state;
    logic        divTick;
    logic        timedOut;
    logic        monitorTick;
    logic [3:0]  failTarget;
    logic        switchActive;
    logic        phaseHeld;
    logic [15:0] ctrlWord;

    bbcc_idle_divider u_idle_divider (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (state.ctrl.converterEnable),
        .divSelect  (state.ctrl.idleClockDivider),
        .sampleTick (divTick)
    );

    assign switchActive = (state.phase == bbcc_pkg::BBCC_HIGHS) ||
                          (state.phase == bbcc_pkg::BBCC_LOWS);
    // Timer restarts at every phase change, so each switch gets its own timeout
    assign phaseHeld = switchActive && next_state.phase == state.phase;

    bbcc_switch_timer u_switch_timer (
        .clk         (clk),
        .reset_n     (reset_n),
        .switchOn    (phaseHeld),
        .timeoutCode (state.ctrl.switchTimeout),
        .expired     (timedOut)
    );

    assign ctrlWord = 16'(state.ctrl);
    // Monitoring only paced by the divider while idle
    assign monitorTick = divTick && state.phase == bbcc_pkg::BBCC_IDLE;

    // Run length 2, 4, 8 or 15
    always_comb begin
        unique case (state.ctrl.okClearCount)
            2'h0: failTarget = 4'h2;
            2'h1: failTarget = 4'h4;
            2'h2: failTarget = 4'h8;
            2'h3: failTarget = 4'hf;
        endcase
    end

    always_comb begin
        next_state = state;
        next_state.sampleStrobe = 1'b0;

        // Write channels, taken in either order
        if (s_axi_awvalid && !state.awTaken && !state.bValid) begin
            next_state.awTaken = 1'b1;
            next_state.awAddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.wTaken && !state.bValid) begin
            next_state.wTaken = 1'b1;
            next_state.wData  = s_axi_wdata;
            next_state.wStrb  = s_axi_wstrb;
        end
        if (state.awTaken && state.wTaken) begin
            next_state.awTaken = 1'b0;
            next_state.wTaken  = 1'b0;
            next_state.bValid  = 1'b1;
            next_state.bResp   = bbcc_pkg::RESP_OKAY;
            if (state.awAddr == bbcc_pkg::CONVERTER_CONTROL_ADDR) begin
                // Upper half of the bus word is unused
                if (state.wStrb[0]) begin
                    next_state.ctrl.converterEnable  =
                        state.wData[bbcc_pkg::ENABLE_POS];
                    next_state.ctrl.idleClockDivider =
                        state.wData[bbcc_pkg::IDLE_DIV_LSB +: 2];
                    next_state.ctrl.switchTimeout    =
                        state.wData[bbcc_pkg::TIMEOUT_LSB +: 3];
                    next_state.ctrl.okClearCount     =
                        state.wData[bbcc_pkg::OK_CLEAR_LSB +: 2];
                end
                if (state.wStrb[1]) begin
                    next_state.ctrl.peakLimitFloor   =
                        state.wData[bbcc_pkg::FLOOR_LSB +: 4];
                    next_state.ctrl.peakLimitCeiling =
                        state.wData[bbcc_pkg::CEILING_LSB +: 4];
                end
            end else if (state.awAddr != bbcc_pkg::CONVERTER_STATUS_ADDR &&
                         state.awAddr != bbcc_pkg::PEAK_LIMIT_ADDR) begin
                next_state.bResp = bbcc_pkg::RESP_SLVERR;
            end
        end
        if (state.bValid && s_axi_bready) begin
            next_state.bValid = 1'b0;
        end

        // Read channel: rvalid only follows an address handshake
        if (s_axi_arvalid && state.arReady) begin
            next_state.arReady = 1'b0;
            next_state.rValid  = 1'b1;
            next_state.rResp  = bbcc_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                bbcc_pkg::CONVERTER_CONTROL_ADDR:
                    next_state.rData = {16'h0000, ctrlWord};
                bbcc_pkg::CONVERTER_STATUS_ADDR:
                    next_state.rData = {26'h0000000, state.failRun,
                                        state.phase != bbcc_pkg::BBCC_OFF,
                                        state.outputOk};
                bbcc_pkg::PEAK_LIMIT_ADDR:
                    next_state.rData = {28'h0000000, state.peakLimit};
                default: begin
                    next_state.rData = 32'h0000_0000;
                    next_state.rResp = bbcc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (state.rValid && s_axi_rready) begin
            next_state.rValid  = 1'b0;
            next_state.arReady = 1'b1;
        end

        // Switching phases
        unique case (state.phase)
            bbcc_pkg::BBCC_OFF: begin
                if (state.ctrl.converterEnable) begin
                    next_state.phase = bbcc_pkg::BBCC_IDLE;
                end
            end
            bbcc_pkg::BBCC_IDLE: begin
                if (needEnergy) begin
                    next_state.phase = bbcc_pkg::BBCC_HIGHS;
                end
            end
            bbcc_pkg::BBCC_HIGHS: begin
                if (peakReached || timedOut) begin
                    next_state.phase = bbcc_pkg::BBCC_LOWS;
                end
            end
            bbcc_pkg::BBCC_LOWS: begin
                if (!peakReached || timedOut) begin
                    next_state.phase = bbcc_pkg::BBCC_IDLE;
                end
            end
        endcase
        if (!state.ctrl.converterEnable) begin
            next_state.phase = bbcc_pkg::BBCC_OFF;
        end

        // Peak limit: step up on timeout, down on quick peak
        if (state.phase == bbcc_pkg::BBCC_HIGHS && timedOut &&
            state.peakLimit < state.ctrl.peakLimitCeiling) begin
            next_state.peakLimit = state.peakLimit + 4'h1;
        end else if (state.phase == bbcc_pkg::BBCC_HIGHS && peakReached &&
                     state.peakLimit > state.ctrl.peakLimitFloor) begin
            next_state.peakLimit = state.peakLimit - 4'h1;
        end
        // Floor first, so the ceiling wins if floor is set above it
        if (next_state.peakLimit < state.ctrl.peakLimitFloor) begin
            next_state.peakLimit = state.ctrl.peakLimitFloor;
        end
        if (next_state.peakLimit > state.ctrl.peakLimitCeiling) begin
            next_state.peakLimit = state.ctrl.peakLimitCeiling;
        end

        // Output monitoring
        if (monitorTick) begin
            next_state.sampleStrobe = 1'b1;
            if (outputOkSample) begin
                next_state.failRun  = 4'h0;
                next_state.outputOk = 1'b1;
            end else if (state.failRun >= failTarget - 4'h1) begin
                next_state.failRun  = failTarget;
                next_state.outputOk = 1'b0;
            end else begin
                next_state.failRun = state.failRun + 4'h1;
            end
        end
        if (state.phase == bbcc_pkg::BBCC_OFF) begin
            next_state.outputOk = 1'b0;
            next_state.failRun  = 4'h0;
        end

        // Registered copies give the power stage glitch-free switch controls
        next_state.onOut   = next_state.phase != bbcc_pkg::BBCC_OFF;
        next_state.highOut = next_state.phase == bbcc_pkg::BBCC_HIGHS;
        next_state.lowOut  = next_state.phase == bbcc_pkg::BBCC_LOWS;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state                       <= '0;
            state.ctrl.peakLimitCeiling <= bbcc_pkg::CEILING_RESET;
            state.ctrl.peakLimitFloor   <= bbcc_pkg::FLOOR_RESET;
            state.ctrl.okClearCount     <= bbcc_pkg::OK_CLEAR_RESET;
            state.ctrl.switchTimeout    <= bbcc_pkg::TIMEOUT_RESET;
            state.ctrl.idleClockDivider <= bbcc_pkg::IDLE_DIV_RESET;
            state.ctrl.converterEnable  <= bbcc_pkg::ENABLE_RESET;
            state.phase                 <= bbcc_pkg::BBCC_OFF;
            state.peakLimit             <= bbcc_pkg::FLOOR_RESET;
            state.arReady               <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready      = state.awTaken;
    assign s_axi_wready       = state.wTaken;
    assign s_axi_bvalid       = state.bValid;
    assign s_axi_bresp        = state.bResp;
    assign s_axi_arready      = state.arReady;
    assign s_axi_rvalid       = state.rValid;
    assign s_axi_rdata        = state.rData;
    assign s_axi_rresp        = state.rResp;
    assign converterOn        = state.onOut;
    assign highSwitchOn       = state.highOut;
    assign lowSwitchOn        = state.lowOut;
    assign outputSampleStrobe = state.sampleStrobe;
    assign peakLimitActive    = state.peakLimit;
    assign output_ok_flag     = state.outputOk;
endmodule : bbcc_converter_control

//--- hdl/bbcc_idle_divider.sv
`timescale 1ns/1ps
module bbcc_idle_divider (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] divSelect,
    // Enable out
    output logic            sampleTick
);
    typedef struct packed {
        logic [4:0] count;
        logic       tick;
    } bbcc_div_state_t;

    bbcc_div_state_t state;
    bbcc_div_state_t next_state;
    logic [4:0]      lastCount;

    // Divide by 4, 8, 16, 32
    assign lastCount = 5'((6'h04 << divSelect) - 6'h01);

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (!run) begin
            next_state.count = 5'h00;
        end else if (state.count >= lastCount) begin
            next_state.count = 5'h00;
            next_state.tick  = 1'b1;
        end else begin
            next_state.count = state.count + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sampleTick = state.tick;
endmodule : bbcc_idle_divider

//--- hdl/bbcc_pkg.sv
package bbcc_pkg;

    // Register map
    localparam logic [31:0] CONVERTER_CONTROL_ADDR = 32'h5000_0080;
    localparam logic [31:0] CONVERTER_STATUS_ADDR  = 32'h5000_0084;
    localparam logic [31:0] PEAK_LIMIT_ADDR        = 32'h5000_0088;

    // Field positions of converter_control
    localparam int ENABLE_POS      = 0;
    localparam int IDLE_DIV_LSB    = 1;
    localparam int TIMEOUT_LSB     = 3;
    localparam int OK_CLEAR_LSB    = 6;
    localparam int FLOOR_LSB       = 8;
    localparam int CEILING_LSB     = 12;

    // Reset values of converter_control fields
    localparam logic [3:0] CEILING_RESET  = 4'h8;
    localparam logic [3:0] FLOOR_RESET    = 4'h4;
    localparam logic [1:0] OK_CLEAR_RESET = 2'h2;
    localparam logic [2:0] TIMEOUT_RESET  = 3'h4;
    localparam logic [1:0] IDLE_DIV_RESET = 2'h1;
    localparam logic       ENABLE_RESET   = 1'h0;

    // Timing
    localparam int CLK_PERIOD_PS     = 25000;
    localparam int TIMEOUT_STEP_PS   = 250000;
    localparam int TIMEOUT_STEP_CYC  = TIMEOUT_STEP_PS / CLK_PERIOD_PS;
    localparam int PEAK_STEP_MA      = 6;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] peakLimitCeiling;
        logic [3:0] peakLimitFloor;
        logic [1:0] okClearCount;
        logic [2:0] switchTimeout;
        logic [1:0] idleClockDivider;
        logic       converterEnable;
    } bbcc_ctrl_t;

    typedef enum logic [1:0] {
        BBCC_OFF   = 2'b00,
        BBCC_IDLE  = 2'b01,
        BBCC_HIGHS = 2'b11,
        BBCC_LOWS  = 2'b10
    } bbcc_phase_t;

endpackage : bbcc_pkg

//--- hdl/bbcc_switch_timer.sv
`timescale 1ns/1ps
module bbcc_switch_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       switchOn,
    input  wire logic [2:0] timeoutCode,
    // Result
    output logic            expired
);
    localparam int CW = $clog2(7 * bbcc_pkg::TIMEOUT_STEP_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          fired;
    } bbcc_tmr_state_t;

    bbcc_tmr_state_t state;
    bbcc_tmr_state_t next_state;
    logic [CW-1:0]   limit;

    assign limit = CW'(timeoutCode) * CW'(bbcc_pkg::TIMEOUT_STEP_CYC);

    always_comb begin
        next_state = state;
        next_state.fired = 1'b0;
        if (!switchOn || timeoutCode == 3'h0) begin
            next_state.count = '0;
        end else if (state.count == limit - CW'(1)) begin
            next_state.count = '0;
            next_state.fired = 1'b1;
        end else begin
            next_state.count = state.count + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign expired = state.fired;
endmodule : bbcc_switch_timer

//--- tb/bbcc_converter_control_props.sv
`timescale 1ns/1ps
module bbcc_converter_control_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Bus handshakes
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Power stage
    input wire logic       peakReached,
    input wire logic       converterOn,
    input wire logic       highSwitchOn,
    input wire logic       lowSwitchOn,
    input wire logic       outputSampleStrobe,
    input wire logic [3:0] peakLimitActive,
    input wire logic       output_ok_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_switch_excl: assert property (!(highSwitchOn && lowSwitchOn))
        else $error("both switches on");
    chk_high_from_idle: assert property (
        $rose(highSwitchOn) |-> $past(converterOn) && !$past(lowSwitchOn))
        else $error("high switch not entered from idle");
    chk_on_from_off: assert property (
        $rose(converterOn) |-> !highSwitchOn && !lowSwitchOn)
        else $error("converter started in a switching phase");
    chk_strobe_gap: assert property (
        outputSampleStrobe |=> !outputSampleStrobe [*3])
        else $error("monitor samples closer than four cycles");
    chk_ok_by_sample: assert property (
        $changed(output_ok_flag) |-> outputSampleStrobe || !converterOn)
        else $error("ok flag moved without a monitor sample");
    chk_limit_down: assert property (
        $rose(lowSwitchOn) && $past(peakReached)
        |-> peakLimitActive <= $past(peakLimitActive))
        else $error("limit rose after peak was reached");
    chk_write_answer: assert property (
        s_axi_awready && s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule : bbcc_converter_control_props

//--- tb/bbcc_converter_control_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module bbcc_converter_control_tb;
    typedef struct packed {
        logic [31:0] wrAddr;
        logic [31:0] wrData;
        logic [1:0]  wrResp;
        logic [31:0] rdAddr;
        logic [31:0] rdData;
        logic [1:0]  rdResp;
    } bbcc_row_t;
    localparam logic [31:0] CTRL   = bbcc_pkg::CONVERTER_CONTROL_ADDR;
    localparam logic [31:0] STAT   = bbcc_pkg::CONVERTER_STATUS_ADDR;
    localparam logic [31:0] PEAK   = bbcc_pkg::PEAK_LIMIT_ADDR;
    localparam logic [31:0] NOADDR = 32'h5000_008c;
    localparam logic [1:0]  OK     = bbcc_pkg::RESP_OKAY;
    localparam logic [1:0]  ER     = bbcc_pkg::RESP_SLVERR;
    localparam bbcc_row_t   ROWS [5] = '{
        '{CTRL, 32'h0000_5a5a, OK, CTRL, 32'h0000_5a5a, OK},
        '{CTRL, 32'hffff_a5a4, OK, CTRL, 32'h0000_a5a4, OK},
        '{NOADDR, 32'h0000_1234, ER, NOADDR, 32'h0000_0000, ER},
        '{STAT, 32'h0000_ffff, OK, CTRL, 32'h0000_a5a4, OK},
        '{PEAK, 32'h0000_000f, OK, PEAK, 32'h0000_0005, OK}};
    localparam int RUNS [4] = '{2, 4, 8, 15};

    logic        clk, reset_n, demand, okLevel;
    logic [7:0]  rampCycles;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, peakLimitActive;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, outputOkSample, peakReached, needEnergy;
    logic        converterOn, highSwitchOn, lowSwitchOn, outputSampleStrobe, output_ok_flag;
    int          errTotal = 0;
    int          nCompared = 0;

    bbcc_converter_control u_bbcc_converter_control (.clk, .reset_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .outputOkSample, .peakReached, .needEnergy, .converterOn,
        .highSwitchOn, .lowSwitchOn, .outputSampleStrobe, .peakLimitActive, .output_ok_flag);
    bbcc_power_stage_model u_bbcc_power_stage_model (.clk, .reset_n, .converterOn,
        .highSwitchOn, .lowSwitchOn, .demand, .okLevel, .rampCycles, .outputOkSample,
        .peakReached, .needEnergy);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic reportAndStop();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : reportAndStop

    // Ready is looked at on the falling edge, so it is what the next rising edge samples
    task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awDone, wDone, bDone;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(negedge clk);
            awDone = s_axi_awvalid && s_axi_awready;
            wDone  = s_axi_wvalid && s_axi_wready;
            bDone  = s_axi_bvalid;
            r      = s_axi_bresp;
            @(posedge clk);
            if (awDone) s_axi_awvalid <= 1'b0;
            if (wDone) s_axi_wvalid <= 1'b0;
        end while (!bDone);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : axiWrite

    task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : axiRead

    task automatic highLen(output int n);
        n = 0;
        do @(negedge clk); while (highSwitchOn);
        do @(negedge clk); while (!highSwitchOn);
        do begin n++; @(negedge clk); end while (highSwitchOn);
        @(posedge clk);
    endtask : highLen

    initial begin
        repeat (60000) @(posedge clk);
        errTotal++;
        reportAndStop();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        reset_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        {demand, okLevel} = 2'b00;
        rampCycles = 8'hff;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        `CHK("limitReset", 4'h4, peakLimitActive)
        `CHK("onReset", 1'b0, converterOn)
        @(posedge clk);
        axiRead(CTRL, d, r);
        `CHK("ctrlReset", 32'h0000_84a2, d)
        foreach (ROWS[i]) begin
            axiWrite(ROWS[i].wrAddr, ROWS[i].wrData, r);
            `CHK("wrResp", ROWS[i].wrResp, r)
            axiRead(ROWS[i].rdAddr, d, r);
            `CHK("rdData", ROWS[i].rdData, d)
            `CHK("rdResp", ROWS[i].rdResp, r)
        end
        // Upper byte alone: ceiling 5 under floor 10, ceiling must win
        s_axi_wstrb <= 4'h2;
        axiWrite(CTRL, 32'h0000_5aff, r);
        s_axi_wstrb <= 4'hf;
        axiRead(CTRL, d, r);
        `CHK("byteLane", 32'h0000_5aa4, d)
        axiRead(PEAK, d, r);
        `CHK("ceilingWins", 32'h0000_0005, d)
        // Limit climbs on timeouts to the ceiling, then falls on quick peaks
        axiWrite(CTRL, 32'h0000_8409, r);
        `CHK("enabled", 1'b1, converterOn)
        demand <= 1'b1;
        highLen(n);
        `CHK("limitUp", 4'h6, peakLimitActive)
        repeat (300) @(posedge clk);
        `CHK("limitCeiling", 4'h8, peakLimitActive)
        rampCycles <= 8'h03;
        repeat (300) @(posedge clk);
        `CHK("limitFloor", 4'h4, peakLimitActive)
        rampCycles <= 8'hc8;
        for (int c = 0; c < 8; c++) begin
            axiWrite(CTRL, 32'h0000_8401 | 32'(c << 3), r);
            highLen(n);
            // Switch must stay on beyond the timeout, so one cycle past it
            `CHK("highTime", 1'b1, (c == 0) ? (n > 70) : (n == 10 * c + 1))
        end
        demand <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            axiWrite(CTRL, 32'h0000_8401 | 32'((k << 6) | (k << 1)), r);
            okLevel <= 1'b1;
            do @(negedge clk); while (!output_ok_flag || !outputSampleStrobe);
            n = 0;
            do begin @(negedge clk); n++; end while (!outputSampleStrobe);
            `CHK("sampleGap", 4 << k, n)
            @(posedge clk);
            okLevel <= 1'b0;
            n = 0;
            do begin @(negedge clk); n += int'(outputSampleStrobe); end while (output_ok_flag);
            `CHK("failRun", RUNS[k], n)
            @(posedge clk);
            axiRead(STAT, d, r);
            `CHK("status", 32'(RUNS[k] << 2) | 32'h0000_0002, d)
        end
        axiWrite(CTRL, 32'h0000_8400, r);
        `CHK("disabled", 1'b0, converterOn)
        reportAndStop();
    end
endmodule : bbcc_converter_control_tb

bind bbcc_converter_control bbcc_converter_control_props u_bbcc_converter_control_props (
    .clk, .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .peakReached, .converterOn, .highSwitchOn, .lowSwitchOn,
    .outputSampleStrobe, .peakLimitActive, .output_ok_flag);

//--- tb/bbcc_power_stage_model.sv
`timescale 1ns/1ps
module bbcc_power_stage_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // From the controller
    input  wire logic       converterOn,
    input  wire logic       highSwitchOn,
    input  wire logic       lowSwitchOn,
    // Scenario knobs
    input  wire logic       demand,
    input  wire logic       okLevel,
    input  wire logic [7:0] rampCycles,
    // Comparators
    output logic            outputOkSample,
    output logic            peakReached,
    output logic            needEnergy
);
    logic [7:0] ramp;

    // Saturates below 8'hff so that value means the peak is never met
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ramp        <= 8'h00;
            peakReached <= 1'b0;
        end else begin
            if (lowSwitchOn)
                ramp <= 8'h00;
            else if (highSwitchOn && ramp != 8'hfe)
                ramp <= ramp + 8'h01;
            peakReached <= highSwitchOn && (ramp >= rampCycles);
        end
    end

    assign needEnergy     = demand && converterOn;
    assign outputOkSample = okLevel;
endmodule : bbcc_power_stage_model
